// [design/psq_pkg.sv]
package psq_pkg;

    // ---------------------------------------------------------------
    // widths and timing
    // ---------------------------------------------------------------
    localparam int PC_W            = 10;
    localparam int ROM_W           = 14;
    localparam int DAT_W           = 8;
    localparam int PHASES          = 4;
    localparam logic [1:0] PH_FETCH   = 2'h0;
    localparam logic [1:0] PH_CAPTURE = 2'h2;
    localparam logic [1:0] PH_LAST    = 2'h3;

    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_PC_LOW   = 6'h06;
    localparam logic [5:0] IDX_TBL_PTR  = 6'h07;
    localparam logic [5:0] IDX_TBL_HIGH = 6'h08;
    localparam logic [5:0] IDX_IRQ_CTRL = 6'h0b;

    // irq control register fields
    localparam int IC_GIE      = 0;
    localparam int IC_EXT_EN   = 1;
    localparam int IC_TMR_EN   = 2;
    localparam int IC_EXT_FLAG = 4;
    localparam int IC_TMR_FLAG = 5;

    // reset values and stack depth
    localparam logic [9:0] PC_RESET    = 10'h000;
    localparam logic [7:0] REG8_RESET  = 8'h00;
    localparam logic [1:0] STK_EMPTY   = 2'h0;
    localparam logic [1:0] STK_DEPTH   = 2'h2;

    // vectors and table page
    localparam logic [9:0] VEC_EXT     = 10'h004;
    localparam logic [9:0] VEC_TMR     = 10'h008;
    localparam logic [1:0] LAST_PAGE   = 2'h3;

    // operation reported by the decoder for the executing instruction
    typedef enum logic [2:0] {
        PSQ_OP_NONE,
        PSQ_OP_SKIP,
        PSQ_OP_JUMP,
        PSQ_OP_CALL,
        PSQ_OP_RET,
        PSQ_OP_INTERRUPT_RETURN,
        PSQ_OP_TRDC,
        PSQ_OP_TRDL
    } psq_op_t;

endpackage

// [design/psq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer
    import psq_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic                    wb_we_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // program memory
    output logic [psq_pkg::PC_W-1:0]     rom_addr_o,
    input  wire logic [psq_pkg::ROM_W-1:0] rom_data_i,
    // decoder
    output logic [psq_pkg::ROM_W-1:0]    exec_word_o,
    output logic                         exec_valid_o,
    output logic                         cycle_start_o,
    input  wire psq_pkg::psq_op_t        op_i,
    input  wire logic [psq_pkg::PC_W-1:0] target_i,
    input  wire logic                    skip_true_i,
    // table read data towards data memory
    output logic [psq_pkg::DAT_W-1:0]    tbl_data_o,
    output logic                         tbl_wr_o,
    // interrupt sources
    input  wire logic                    ext_int_n_i,
    input  wire logic                    tmr_ovf_i,
    output logic                         irq_ack_o
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [1:0]       phase, stack_index;
    logic [PC_W-1:0]  pc, tbl_addr, stk0, stk1, push_val, next_pc;
    logic [ROM_W-1:0] fetch_q, hold_q;
    logic [7:0]       table_pointer, table_high_byte, next_rdata;
    logic [5:0]       wb_idx;
    logic             cyc_end, tbl_busy, pcl_flush, stk_full;
    logic             global_irq_enable, ext_en, tmr_en;
    logic             ext_irq_request_flag, tmr_flag;
    logic             ext_int_prev, ext_fall;
    logic             wb_req, wb_wr, wr_pcl, wr_table_address_pointer, wr_ctrl;
    logic             take_ext, take_tmr, irq_take_ok, interrupt_return_now;
    logic             exec_xfer, exec_tbl, exec_skip, do_push, do_pop;

    // true when the executing op changes the program counter
    function automatic logic is_xfer(input psq_op_t op);
        is_xfer = (op == PSQ_OP_JUMP) || (op == PSQ_OP_CALL) ||
                  (op == PSQ_OP_RET)  || (op == PSQ_OP_INTERRUPT_RETURN);
    endfunction

    // ---------------------------------------------------------------
    // phase generator
    // ---------------------------------------------------------------
    // four phases per instruction cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= PH_FETCH;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign cyc_end = (phase == PH_LAST);

    // pulse marking the first clock of each instruction cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycle_start_o <= 1'b0;
        end else begin
            cycle_start_o <= cyc_end;
        end
    end

    // ---------------------------------------------------------------
    // wishbone decode
    // ---------------------------------------------------------------
    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_idx  = wb_adr_i[7:2];
    assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
    assign wr_pcl  = wb_wr && (wb_idx == IDX_PC_LOW);
    assign wr_table_address_pointer = wb_wr && (wb_idx == IDX_TBL_PTR);
    assign wr_ctrl = wb_wr && (wb_idx == IDX_IRQ_CTRL);

    // read mux, stack never visible
    always_comb begin
        next_rdata = REG8_RESET;
        case (wb_idx)
            IDX_PC_LOW:   next_rdata = pc[7:0];
            IDX_TBL_PTR:  next_rdata = table_pointer;
            IDX_TBL_HIGH: next_rdata = table_high_byte;
            IDX_IRQ_CTRL: begin
                next_rdata[IC_GIE]      = global_irq_enable;
                next_rdata[IC_EXT_EN]   = ext_en;
                next_rdata[IC_TMR_EN]   = tmr_en;
                next_rdata[IC_EXT_FLAG] = ext_irq_request_flag;
                next_rdata[IC_TMR_FLAG] = tmr_flag;
            end
            default:      next_rdata = REG8_RESET;
        endcase
    end

    // single-cycle registered answer, every address acked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= {24'h00_0000, next_rdata};
            end
        end
    end

    // table pointer, freely writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_pointer <= REG8_RESET;
        end else if (wr_table_address_pointer) begin
            table_pointer <= wb_dat_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // interrupt requests
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_int_prev <= 1'b1;
        end else begin
            ext_int_prev <= ext_int_n_i;
        end
    end

    assign ext_fall = ext_int_prev && !ext_int_n_i;
    assign stk_full = (stack_index == STK_DEPTH);

    // requests wait while stack is full or an op owns the cycle
    assign take_ext = cyc_end && global_irq_enable && ext_en &&
                      ext_irq_request_flag && !stk_full;
    assign take_tmr = cyc_end && global_irq_enable && tmr_en &&
                      tmr_flag && !stk_full && !take_ext;

    // control register, hardware set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_enable    <= 1'b0;
            ext_en               <= 1'b0;
            tmr_en               <= 1'b0;
            ext_irq_request_flag <= 1'b0;
            tmr_flag             <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                global_irq_enable    <= wb_dat_i[IC_GIE];
                ext_en               <= wb_dat_i[IC_EXT_EN];
                tmr_en               <= wb_dat_i[IC_TMR_EN];
                ext_irq_request_flag <= wb_dat_i[IC_EXT_FLAG];
                tmr_flag             <= wb_dat_i[IC_TMR_FLAG];
            end
            if (irq_take_ok && take_ext) begin
                ext_irq_request_flag <= 1'b0;
                global_irq_enable    <= 1'b0;
            end
            if (irq_take_ok && take_tmr) begin
                tmr_flag          <= 1'b0;
                global_irq_enable <= 1'b0;
            end
            if (interrupt_return_now) begin
                global_irq_enable <= 1'b1;
            end
            if (ext_fall) begin
                ext_irq_request_flag <= 1'b1;
            end
            if (tmr_ovf_i) begin
                tmr_flag <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // sequencing decisions for the end of the cycle
    // ---------------------------------------------------------------
    assign exec_xfer = exec_valid_o && is_xfer(op_i);
    assign exec_skip = exec_valid_o && (op_i == PSQ_OP_SKIP) && skip_true_i;
    assign exec_tbl  = exec_valid_o &&
                       ((op_i == PSQ_OP_TRDC) || (op_i == PSQ_OP_TRDL));
    assign irq_take_ok = !tbl_busy && !pcl_flush && !wr_pcl &&
                         !exec_xfer && !exec_skip && !exec_tbl;
    assign interrupt_return_now  = cyc_end && !tbl_busy && !pcl_flush && !wr_pcl &&
                       exec_valid_o && (op_i == PSQ_OP_INTERRUPT_RETURN);

    // stack actions and next program counter
    always_comb begin
        do_push  = 1'b0;
        do_pop   = 1'b0;
        push_val = pc;
        next_pc  = pc;
        if (cyc_end && !tbl_busy && !pcl_flush && !wr_pcl) begin
            if (exec_xfer) begin
                case (op_i)
                    PSQ_OP_JUMP: next_pc = target_i;
                    PSQ_OP_CALL: begin
                        next_pc  = target_i;
                        do_push  = 1'b1;
                        push_val = pc; // return to word after call
                    end
                    PSQ_OP_RET,
                    PSQ_OP_INTERRUPT_RETURN: begin
                        next_pc = stk0;
                        do_pop  = 1'b1;
                    end
                    default: next_pc = pc;
                endcase
            end else if (exec_skip || exec_tbl) begin
                next_pc = pc + 10'h001;
            end else if (irq_take_ok && (take_ext || take_tmr)) begin
                do_push  = 1'b1;
                push_val = pc; // discarded word is re-fetched on return
                next_pc  = take_ext ? VEC_EXT : VEC_TMR;
            end else begin
                next_pc = pc + 10'h001;
            end
        end
    end

    // ---------------------------------------------------------------
    // program counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= PC_RESET;
        end else if (wr_pcl) begin
            pc <= {pc[9:8], wb_dat_i[7:0]};
        end else begin
            pc <= next_pc;
        end
    end

    // flush the in-flight fetch after a low-byte write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcl_flush <= 1'b0;
        end else if (wr_pcl && !cyc_end) begin
            pcl_flush <= 1'b1;
        end else if (cyc_end) begin
            pcl_flush <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // return stack, top in stk0
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stk0        <= PC_RESET;
            stk1        <= PC_RESET;
            stack_index <= STK_EMPTY;
        end else if (do_push) begin
            stk1 <= stk0;
            stk0 <= push_val;
            if (!stk_full) begin
                stack_index <= stack_index + 2'h1;
            end
        end else if (do_pop) begin
            stk0 <= stk1;
            if (stack_index != STK_EMPTY) begin
                stack_index <= stack_index - 2'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // program memory port and fetch pipeline
    // ---------------------------------------------------------------
    // table cycle borrows the port, otherwise pc fetches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rom_addr_o <= PC_RESET;
        end else begin
            rom_addr_o <= tbl_busy ? tbl_addr : pc;
        end
    end

    // capture the fetched word mid cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_q <= 14'h0000;
        end else if (phase == PH_CAPTURE && !tbl_busy) begin
            fetch_q <= rom_data_i;
        end
    end

    // hand fetched word to execute, or insert a dummy cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exec_word_o  <= 14'h0000;
            exec_valid_o <= 1'b0;
            hold_q       <= 14'h0000;
        end else if (cyc_end) begin
            if (tbl_busy) begin
                exec_word_o  <= hold_q;
                exec_valid_o <= 1'b1;
            end else if (pcl_flush || wr_pcl || exec_xfer || exec_skip) begin
                exec_valid_o <= 1'b0;
            end else if (exec_tbl) begin
                hold_q       <= fetch_q;
                exec_valid_o <= 1'b0;
            end else if (irq_take_ok && (take_ext || take_tmr)) begin
                exec_valid_o <= 1'b0;
            end else begin
                exec_word_o  <= fetch_q;
                exec_valid_o <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // table reads
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbl_busy <= 1'b0;
            tbl_addr <= PC_RESET;
        end else if (cyc_end) begin
            tbl_busy <= !tbl_busy && !pcl_flush && !wr_pcl && exec_tbl;
            if (op_i == PSQ_OP_TRDL) begin
                tbl_addr <= {LAST_PAGE, table_pointer};
            end else begin
                tbl_addr <= {pc[9:8], table_pointer};
            end
        end
    end

    // table word split, high byte kept until next table read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_high_byte <= REG8_RESET;
            tbl_data_o      <= REG8_RESET;
            tbl_wr_o        <= 1'b0;
        end else begin
            tbl_wr_o <= 1'b0;
            if (tbl_busy && phase == PH_CAPTURE) begin
                table_high_byte <= {2'h0, rom_data_i[13:8]};
                tbl_data_o      <= rom_data_i[7:0];
                tbl_wr_o        <= 1'b1;
            end
        end
    end

    // acknowledge pulse at vector load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ack_o <= 1'b0;
        end else begin
            irq_ack_o <= cyc_end && irq_take_ok && (take_ext || take_tmr);
        end
    end

endmodule
`default_nettype wire

// [dv/psq_rom_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psq_rom_model
    import psq_pkg::*;
(
    input  wire logic [psq_pkg::PC_W-1:0] addr_i,
    output logic [psq_pkg::ROM_W-1:0]     data_o
);
    // address-derived words, every page and word distinct
    assign data_o = {addr_i[9:8] ^ 2'h2, addr_i[3:0] ^ 4'h9, addr_i[7:0]};
endmodule
`default_nettype wire

// [dv/psq_sequencer_props.sv]
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_props
    import psq_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_ack_o,
    input wire logic [9:0]       rom_addr_o,
    input wire logic [13:0]      exec_word_o,
    input wire logic             exec_valid_o,
    input wire logic             cycle_start_o,
    input wire psq_pkg::psq_op_t op_i,
    input wire logic [9:0]       target_i,
    input wire logic             skip_true_i,
    input wire logic             tbl_wr_o,
    input wire logic             irq_ack_o
);
    logic [1:0] ph;
    logic       at_end;

    // phase count restarted by each cycle start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph <= 2'h0;
        end else if (cycle_start_o) begin
            ph <= 2'h1;
        end else begin
            ph <= ph + 2'h1;
        end
    end
    // last clock of an executing cycle
    assign at_end = (ph == PH_LAST) && exec_valid_o;

    default clocking dck @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_cycle_four: assert property (
        cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
        else $error("cycle not four clocks");
    a_exec_hold: assert property (
        cycle_start_o |=> ($stable(exec_word_o) && $stable(exec_valid_o)) [*3])
        else $error("executing word moved in cycle");
    a_xfer_dummy: assert property (
        at_end && op_i inside {PSQ_OP_JUMP, PSQ_OP_CALL, PSQ_OP_RET,
        PSQ_OP_INTERRUPT_RETURN} |=> cycle_start_o && !exec_valid_o)
        else $error("no dummy after transfer");
    a_table_dummy: assert property (
        at_end && op_i inside {PSQ_OP_TRDC, PSQ_OP_TRDL}
        |=> !exec_valid_o ##[2:4] tbl_wr_o)
        else $error("table read not two cycles");
    a_jump_target: assert property (
        at_end && op_i inside {PSQ_OP_JUMP, PSQ_OP_CALL}
        |-> ##2 rom_addr_o == $past(target_i, 2))
        else $error("jump target not fetched");
    a_skip_two: assert property (
        at_end && op_i == PSQ_OP_SKIP && skip_true_i |=> !exec_valid_o
        ##1 rom_addr_o == $past(rom_addr_o, 2) + 10'h001)
        else $error("skip did not reach plus two");
    a_ack_prompt: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer late or long");
    a_irq_vector: assert property (
        irq_ack_o |-> !exec_valid_o
        ##1 (rom_addr_o == VEC_EXT || rom_addr_o == VEC_TMR))
        else $error("interrupt vector wrong");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import psq_pkg::*;

    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        skip_true_i, ext_int_n_i, tmr_ovf_i, irq_ack_o;
    logic        exec_valid_o, cycle_start_o, tbl_wr_o;
    logic [7:0]  wb_adr_i, tbl_data_o, tw_d;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [9:0]  rom_addr_o, target_i, pc_exp, irq_vec;
    logic [13:0] rom_data_i, exec_word_o;
    logic [9:0]  stk [2];
    psq_op_t     op_i;
    int          sp, err_total, total_checks, irq_n, tw_n;

    psq_sequencer DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rom_addr_o(rom_addr_o),
        .rom_data_i(rom_data_i), .exec_word_o(exec_word_o),
        .exec_valid_o(exec_valid_o), .cycle_start_o(cycle_start_o),
        .op_i(op_i), .target_i(target_i), .skip_true_i(skip_true_i),
        .tbl_data_o(tbl_data_o), .tbl_wr_o(tbl_wr_o),
        .ext_int_n_i(ext_int_n_i), .tmr_ovf_i(tmr_ovf_i),
        .irq_ack_o(irq_ack_o));
    psq_rom_model ROM (.addr_i(rom_addr_o), .data_o(rom_data_i));

    // expected program word at an address
    function automatic logic [31:0] wd(input logic [9:0] a);
        return {18'h0, a[9:8] ^ 2'h2, a[3:0] ^ 4'h9, a[7:0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // classic single wishbone cycle, waits for ack
    task automatic bus(input logic w, input logic [5:0] ix,
                       input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {ix, 2'h0};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!wb_ack_o && n < 20);
        if (n >= 20) begin
            err_total++;
            summarize();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // reference return stack, oldest entry dropped when full
    task automatic push(input logic [9:0] v);
        if (sp == 2) begin
            stk[0] = stk[1];
            sp = 1;
        end
        stk[sp] = v;
        sp++;
    endtask
    // one executed instruction: count dummies, check word, give op
    task automatic step(input psq_op_t op, input logic [9:0] t,
                        input logic sk, input int nd, input logic w);
        int n;
        int k;
        n = 0;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            if (tbl_wr_o) begin
                tw_n++;
                tw_d = tbl_data_o;
            end
            if (irq_ack_o) begin
                irq_n++;
                push(pc_exp);
                pc_exp = irq_vec;
            end
            if (cycle_start_o && !exec_valid_o) n++;
        end while (!(cycle_start_o && exec_valid_o) && k < 64);
        if (k >= 64) begin
            err_total++;
            summarize();
        end
        if (w) check(exec_word_o, wd(pc_exp));
        if (nd >= 0) check(n, nd);
        op_i        <= op;
        target_i    <= t;
        skip_true_i <= sk;
        case (op)
            PSQ_OP_SKIP: pc_exp = pc_exp + (sk ? 10'h002 : 10'h001);
            PSQ_OP_JUMP: pc_exp = t;
            PSQ_OP_CALL: begin
                push(pc_exp + 10'h001);
                pc_exp = t;
            end
            PSQ_OP_RET, PSQ_OP_INTERRUPT_RETURN: begin
                if (sp > 0) sp--;
                pc_exp = stk[sp];
            end
            default: pc_exp = pc_exp + 10'h001;
        endcase
    endtask

    task automatic t_reset;
        step(PSQ_OP_NONE, 10'h0, 1'b0, -1, 1'b1);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 0, 1'b1);
        bus(1'b0, IDX_TBL_PTR, 8'h00);
        check(rd, 32'h0);
        bus(1'b0, 6'h3f, 8'h00);
        check(rd, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_flow;
        step(PSQ_OP_JUMP, 10'h120, 1'b0, -1, 1'b0);
        step(PSQ_OP_SKIP, 10'h0, 1'b1, 1, 1'b1);
        step(PSQ_OP_SKIP, 10'h0, 1'b0, 1, 1'b1);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 0, 1'b1);
        $display("flow test done");
    endtask
    task automatic t_table;
        bus(1'b1, IDX_TBL_PTR, 8'h34);
        bus(1'b1, IDX_TBL_HIGH, 8'h55);
        bus(1'b0, IDX_TBL_HIGH, 8'h00);
        check(rd, 32'h0);
        bus(1'b0, IDX_TBL_PTR, 8'h00);
        check(rd, 32'h34);
        step(PSQ_OP_JUMP, 10'h2a0, 1'b0, -1, 1'b0);
        step(PSQ_OP_TRDC, 10'h0, 1'b0, 1, 1'b1);
        tw_n = 0;
        step(PSQ_OP_TRDL, 10'h0, 1'b0, 1, 1'b1);
        check(tw_n, 1);
        check(tw_d, wd(10'h234) & 32'hff);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 1, 1'b1);
        check(tw_d, wd(10'h334) & 32'hff);
        bus(1'b0, IDX_TBL_HIGH, 8'h00);
        check(rd, wd(10'h334) >> 8);
        $display("table test done");
    endtask
    task automatic t_pcw;
        step(PSQ_OP_JUMP, 10'h1f0, 1'b0, -1, 1'b0);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 1, 1'b1);
        bus(1'b1, IDX_PC_LOW, 8'h80);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 1, 1'b0);
        check(exec_word_o, wd(10'h180));
        pc_exp = 10'h181;
        step(PSQ_OP_NONE, 10'h0, 1'b0, 0, 1'b1);
        $display("pc write test done");
    endtask
    task automatic t_irq;
        irq_vec = VEC_EXT;
        bus(1'b1, IDX_IRQ_CTRL, 8'h03);
        ext_int_n_i <= 1'b0;
        step(PSQ_OP_JUMP, 10'h300, 1'b0, -1, 1'b0);
        repeat (3) step(PSQ_OP_NONE, 10'h0, 1'b0, -1, 1'b1);
        check(irq_n, 1);
        bus(1'b0, IDX_IRQ_CTRL, 8'h00);
        check(rd, 32'h02);
        step(PSQ_OP_INTERRUPT_RETURN, 10'h0, 1'b0, -1, 1'b0);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 1, 1'b1);
        bus(1'b0, IDX_IRQ_CTRL, 8'h00);
        check(rd, 32'h03);
        ext_int_n_i <= 1'b1;
        $display("interrupt test done");
    endtask
    task automatic t_full;
        irq_vec = VEC_TMR;
        step(PSQ_OP_JUMP, 10'h040, 1'b0, -1, 1'b0);
        step(PSQ_OP_CALL, 10'h080, 1'b0, 1, 1'b1);
        step(PSQ_OP_CALL, 10'h0c0, 1'b0, 1, 1'b1);
        step(PSQ_OP_CALL, 10'h100, 1'b0, 1, 1'b1);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 1, 1'b1);
        bus(1'b1, IDX_IRQ_CTRL, 8'h05);
        tmr_ovf_i <= 1'b1;
        @(posedge clk_i);
        tmr_ovf_i <= 1'b0;
        repeat (2) step(PSQ_OP_NONE, 10'h0, 1'b0, -1, 1'b0);
        check(irq_n, 1);
        step(PSQ_OP_RET, 10'h0, 1'b0, -1, 1'b0);
        step(PSQ_OP_INTERRUPT_RETURN, 10'h0, 1'b0, -1, 1'b1);
        step(PSQ_OP_RET, 10'h0, 1'b0, 1, 1'b1);
        step(PSQ_OP_NONE, 10'h0, 1'b0, 1, 1'b1);
        $display("full stack test done");
    endtask

    // free-running bench clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // reset, then the scenarios in order
    initial begin
        {wb_we_i, wb_cyc_i, wb_stb_i, skip_true_i, tmr_ovf_i} = '0;
        {wb_adr_i, wb_dat_i, target_i, pc_exp, irq_vec} = '0;
        {sp, err_total, total_checks, irq_n, tw_n} = '0;
        stk = '{10'h0, 10'h0};
        wb_sel_i = 4'hf;
        op_i = PSQ_OP_NONE;
        ext_int_n_i = 1'b1;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_flow();
        t_table();
        t_pcw();
        t_irq();
        t_full();
        summarize();
    end
endmodule

bind psq_sequencer psq_sequencer_props CHK (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rom_addr_o(rom_addr_o),
    .exec_word_o(exec_word_o), .exec_valid_o(exec_valid_o),
    .cycle_start_o(cycle_start_o), .op_i(op_i), .target_i(target_i),
    .skip_true_i(skip_true_i), .tbl_wr_o(tbl_wr_o),
    .irq_ack_o(irq_ack_o));
`default_nettype wire
